/* File: inc/pmcp_map.svh */
// Register offsets, field positions, reset values and timing counts of the clock controller.
`ifndef PMCP_MAP_SVH
`define PMCP_MAP_SVH
`define PMCP_OFF_CLK_CTRL    8'h00
`define PMCP_OFF_AWAKE_CTRL  8'h04
`define PMCP_OFF_STATUS      8'h08
`define PMCP_OFF_DIAG        8'h0C
`define PMCP_BIT_SLOW_EN     2
`define PMCP_BIT_DIV_LO      0
`define PMCP_BIT_RTC_IE      3
`define PMCP_BIT_AWAKE_EN    0
`define PMCP_BIT_LONG_STAB   1
`define PMCP_CLK_CTRL_RST    32'h00000000
`define PMCP_AWAKE_RST       32'h00000000
`define PMCP_STAB_SHORT      16'h0100
`define PMCP_STAB_LONG       16'h1000
`define PMCP_IMASK_HALT      2'h2
`define PMCP_RESP_OKAY       2'h0
`define PMCP_RESP_SLVERR     2'h2
`endif

/* File: inc/pmcp_pkg.sv */
// Types shared by the clock controller modules.
package pmcp_pkg;
  typedef enum logic [2:0] {
    PMCP_RUN,
    PMCP_WAIT,
    PMCP_HALT,
    PMCP_ACT_HALT,
    PMCP_STAB
  } pmcp_mode_t;
endpackage : pmcp_pkg

/* File: inc/pmcp_div_if.sv */
// Carrier between the controller and its clock divider.
interface pmcp_div_if;
  logic       run_en;
  logic       slow_en;
  logic [1:0] sel;
  logic       tick;
  modport ctrl (output run_en, output slow_en, output sel, input tick);
  modport div  (input run_en, input slow_en, input sel, output tick);
endinterface : pmcp_div_if

/* File: logic/pmcp_divider.sv */
// Master clock prescaler that produces the cpu clock enable tick.
`include "pmcp_map.svh"
module pmcp_divider
  import pmcp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  pmcp_div_if.div   dv
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } pmcp_div_st_t;
  pmcp_div_st_t s_q, s_d;

  // Divide ratio minus one: 2, 4, 8 or 16 in slow state, else 1.
  function automatic logic [3:0] last_count(input logic slow, input logic [1:0] sel);
    last_count = slow ? 4'((5'h02 << sel) - 5'h01) : 4'h0;
  endfunction : last_count

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!dv.run_en) begin
      s_d.cnt = 4'h0;
    end else if (s_q.cnt >= last_count(dv.slow_en, dv.sel)) begin
      s_d.cnt = 4'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dv.tick = s_q.tick;
endmodule : pmcp_divider

/* File: logic/pmcp_ctrl.sv */
// Power mode controller and cpu clock prescaler with an AXI4-Lite register port.
// Functional notes
// R1 - After reset enter run state, clocking from the master clock.
// R2 - Slow enable bit and two-bit divider select control the slow state.
// R3 - Slow state divides the master clock by 2, 4, 8 or 16.
// R4 - CPU and peripherals both use the divided clock in slow state.
// R5 - Wait entered during slow state gives slow-wait.
// R6 - Halt entered only with rtc interrupt enable and auto-wake enable cleared; the code also enters halt with auto-wake enable set.
// R7 - Halt with rtc interrupt enable set enters active halt.
// R8 - Halt left only on reset or a wake-capable interrupt.
// R9 - On leaving halt restart oscillator, wait 256 or 4096 cycles.
// R10 - After the delay resume by interrupt service or reset vector fetch.
// R11 - On halt entry the interrupt mask bits become binary 10.
// R12 - In halt the main oscillator stops, halting processing and peripherals.
// R13 - Peripherals on a separate clock keep running during halt.
// R14 - Option bit: watchdog enabled without halt compatibility makes halt reset.
// R15 - In auto-wake halt the auto-wake interrupt also exits halt.
// R16 - Interrupt entry pushes condition code and sets mask to its level.
// R17 - Prescaler, clock-out and rtc timer work independently and simultaneously.
// R18 - Slow enable and divider select reset to zero.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`include "pmcp_map.svh"
module pmcp_ctrl
  import pmcp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_wait_req,
  input  wire logic        i_halt_req,
  input  wire logic        i_wake_irq,
  input  wire logic        i_auto_wake_irq,
  input  wire logic        i_ext_reset,
  input  wire logic        i_watchdog_en,
  input  wire logic        i_watchdog_stop_compat_option,
  input  wire logic        i_any_irq,
  output logic             o_cpu_clock_en,
  output logic             o_periph_clock_en,
  output logic             o_osc_on,
  output logic             o_force_imask,
  output logic [1:0]       o_imask_value,
  output logic             o_resume_irq,
  output logic             o_resume_reset,
  output logic             o_watchdog_reset,
  output logic             o_active_halt,
  output logic [2:0]       o_mode
);
  typedef struct packed {
    pmcp_mode_t  mode;
    logic        slow_state_enable;
    logic [1:0]  slow_divider_select;
    logic        rtc_interrupt_enable;
    logic        auto_wake_enable;
    logic        long_stab;
    logic        wake_by_reset;
    logic [15:0] stab_cnt;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        cpu_en;
    logic        per_en;
    logic        osc_on;
    logic        force_imask;
    logic        res_irq;
    logic        res_rst;
    logic        wdg_rst;
    logic        act_halt;
  } pmcp_st_t;
  pmcp_st_t s_q, s_d;
  pmcp_div_if dv ();

  logic [2:0] wake_sync_q, awake_sync_q, rst_sync_q;
  logic       wake_q, awake_q, xrst_q;

  // Pins pass three flops; a level change counts once stages two and three agree.
  // These run on the controller clock, which keeps going while the main oscillator is off. [R13]
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wake_sync_q  <= 3'h0;
      awake_sync_q <= 3'h0;
      rst_sync_q   <= 3'h0;
      wake_q       <= 1'b0;
      awake_q      <= 1'b0;
      xrst_q       <= 1'b0;
    end else begin
      wake_sync_q  <= {wake_sync_q[1:0], i_wake_irq};
      awake_sync_q <= {awake_sync_q[1:0], i_auto_wake_irq};
      rst_sync_q   <= {rst_sync_q[1:0], i_ext_reset};
      if (wake_sync_q[1] == wake_sync_q[2]) begin
        wake_q <= wake_sync_q[2];
      end
      if (awake_sync_q[1] == awake_sync_q[2]) begin
        awake_q <= awake_sync_q[2];
      end
      if (rst_sync_q[1] == rst_sync_q[2]) begin
        xrst_q <= rst_sync_q[2];
      end
    end
  end

  assign dv.run_en  = (s_q.mode == PMCP_RUN) || (s_q.mode == PMCP_WAIT); // [R12]
  assign dv.slow_en = s_q.slow_state_enable; // [R2]
  assign dv.sel     = s_q.slow_divider_select; // [R3]

  pmcp_divider u_div (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .dv        (dv)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  logic [31:0] ctrl_word;
  logic [31:0] awake_word;
  logic [31:0] wr_word;
  logic        do_write;
  logic        halt_wake;

  assign ctrl_word  = {28'h0, s_q.rtc_interrupt_enable, s_q.slow_state_enable,
                       s_q.slow_divider_select};
  assign awake_word = {30'h0, s_q.long_stab, s_q.auto_wake_enable};
  // Decided from registers and pins only, so that it never depends on the next state.
  assign do_write   = (s_q.aw_got || i_awvalid) && (s_q.w_got || i_wvalid) && !s_q.bvalid;
  // Wake-capable interrupt, or the auto-wake one when that is enabled.
  assign halt_wake  = wake_q || (s_q.auto_wake_enable && awake_q); // [R8] [R15]

  always_comb begin
    s_d = s_q;
    wr_word = 32'h0;
    s_d.res_irq = 1'b0;
    s_d.res_rst = 1'b0;
    s_d.wdg_rst = 1'b0;
    s_d.force_imask = 1'b0;
    if (i_awvalid && !s_q.aw_got) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && !s_q.w_got) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = i_wdata;
      s_d.w_strb = i_wstrb;
    end
    if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_write) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `PMCP_RESP_OKAY;
      case (s_d.aw_addr)
        `PMCP_OFF_CLK_CTRL: begin
          wr_word = merge(ctrl_word, s_d.w_data, s_d.w_strb);
          s_d.slow_state_enable    = wr_word[`PMCP_BIT_SLOW_EN]; // [R2]
          s_d.slow_divider_select  = wr_word[`PMCP_BIT_DIV_LO +: 2]; // [R2]
          s_d.rtc_interrupt_enable = wr_word[`PMCP_BIT_RTC_IE];
        end
        `PMCP_OFF_AWAKE_CTRL: begin
          wr_word = merge(awake_word, s_d.w_data, s_d.w_strb);
          s_d.auto_wake_enable = wr_word[`PMCP_BIT_AWAKE_EN];
          s_d.long_stab        = wr_word[`PMCP_BIT_LONG_STAB];
        end
        `PMCP_OFF_STATUS, `PMCP_OFF_DIAG: begin
          s_d.bresp = `PMCP_RESP_OKAY;
        end
        default: begin
          s_d.bresp = `PMCP_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (i_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `PMCP_RESP_OKAY;
      case (i_araddr)
        `PMCP_OFF_CLK_CTRL:   s_d.rdata = ctrl_word;
        `PMCP_OFF_AWAKE_CTRL: s_d.rdata = awake_word;
        `PMCP_OFF_STATUS:     s_d.rdata = {27'h0, s_q.osc_on, s_q.wake_by_reset, 
                                           s_q.act_halt, s_q.mode == PMCP_HALT,
                                           s_q.mode == PMCP_WAIT};
        `PMCP_OFF_DIAG:       s_d.rdata = {16'h0, s_q.stab_cnt};
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = `PMCP_RESP_SLVERR;
        end
      endcase
    end
    case (s_q.mode)
      PMCP_RUN: begin
        if (i_halt_req) begin
          if (i_watchdog_en && !i_watchdog_stop_compat_option) begin
            s_d.wdg_rst = 1'b1; // [R14]
          end else if (s_q.rtc_interrupt_enable) begin
            s_d.mode     = PMCP_ACT_HALT; // [R7]
            s_d.act_halt = 1'b1;
            s_d.force_imask = 1'b1; // [R11]
          end else if (!s_q.auto_wake_enable) begin
            s_d.mode        = PMCP_HALT; // [R6]
            s_d.osc_on      = 1'b0; // [R12]
            s_d.force_imask = 1'b1; // [R11]
          end else begin
            s_d.mode        = PMCP_HALT; // [R15]
            s_d.osc_on      = 1'b0;
            s_d.force_imask = 1'b1;
          end
        end else if (i_wait_req) begin
          s_d.mode = PMCP_WAIT; // [R5]
        end
      end
      PMCP_WAIT: begin
        if (i_any_irq || xrst_q) begin
          s_d.mode = PMCP_RUN;
        end
      end
      PMCP_HALT, PMCP_ACT_HALT: begin
        if (xrst_q || halt_wake || (s_q.mode == PMCP_ACT_HALT && i_any_irq)) begin
          s_d.mode          = PMCP_STAB; // [R8]
          s_d.osc_on        = 1'b1; // [R9]
          s_d.act_halt      = 1'b0;
          s_d.wake_by_reset = xrst_q;
          s_d.stab_cnt      = s_q.long_stab ? `PMCP_STAB_LONG : `PMCP_STAB_SHORT; // [R9]
        end
      end
      PMCP_STAB: begin
        if (s_q.stab_cnt <= 16'h0001) begin
          s_d.stab_cnt = 16'h0;
          s_d.mode     = PMCP_RUN;
          s_d.res_rst  = s_q.wake_by_reset; // [R10]
          s_d.res_irq  = !s_q.wake_by_reset; // [R10] [R16]
        end else begin
          s_d.stab_cnt = s_q.stab_cnt - 16'h0001;
        end
      end
      default: begin
        s_d.mode = PMCP_RUN;
      end
    endcase
    s_d.cpu_en = dv.tick && (s_d.mode == PMCP_RUN); // [R4]
    s_d.per_en = dv.tick && (s_d.mode == PMCP_RUN || s_d.mode == PMCP_WAIT); // [R4] [R17]
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_q        <= '0; // [R18]
      s_q.mode   <= PMCP_RUN; // [R1]
      s_q.osc_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_awready         = !s_q.aw_got;
  assign o_wready          = !s_q.w_got;
  assign o_bvalid          = s_q.bvalid;
  assign o_bresp           = s_q.bresp;
  assign o_arready         = !s_q.rvalid;
  assign o_rvalid          = s_q.rvalid;
  assign o_rdata           = s_q.rdata;
  assign o_rresp           = s_q.rresp;
  assign o_cpu_clock_en    = s_q.cpu_en;
  assign o_periph_clock_en = s_q.per_en;
  assign o_osc_on          = s_q.osc_on;
  assign o_force_imask     = s_q.force_imask;
  assign o_imask_value     = `PMCP_IMASK_HALT; // [R11]
  assign o_resume_irq      = s_q.res_irq;
  assign o_resume_reset    = s_q.res_rst;
  assign o_watchdog_reset  = s_q.wdg_rst;
  assign o_active_halt     = s_q.act_halt;
  assign o_mode            = s_q.mode;

  halt_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R6]
    (s_q.mode == PMCP_RUN && i_halt_req && !i_watchdog_en && !s_q.rtc_interrupt_enable)
    |=> s_q.mode == PMCP_HALT && !s_q.osc_on)
    else $error("halt not entered");
  act_halt_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
    (s_q.mode == PMCP_RUN && i_halt_req && !i_watchdog_en && s_q.rtc_interrupt_enable)
    |=> s_q.mode == PMCP_ACT_HALT)
    else $error("active halt not entered");
  osc_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
    s_q.mode == PMCP_HALT |-> !s_q.osc_on && !s_q.cpu_en)
    else $error("oscillator running in halt");
  sequence halt_exit_s;
    s_q.mode == PMCP_HALT ##1 s_q.mode == PMCP_STAB;
  endsequence
  stab_start_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R9]
    halt_exit_s |-> s_q.osc_on && (s_q.stab_cnt == `PMCP_STAB_SHORT ||
                                   s_q.stab_cnt == `PMCP_STAB_LONG))
    else $error("bad stabilisation start");
  stab_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R10]
    (s_q.mode == PMCP_STAB && s_q.stab_cnt == 16'h0001)
    |=> (s_q.res_irq ^ s_q.res_rst) && s_q.mode == PMCP_RUN)
    else $error("no resume after delay");
  imask_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R11]
    $rose(s_q.mode == PMCP_HALT) |-> s_q.force_imask && o_imask_value == 2'h2)
    else $error("mask not forced");
  wdg_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
    (s_q.mode == PMCP_RUN && i_halt_req && i_watchdog_en && !i_watchdog_stop_compat_option)
    |=> s_q.wdg_rst && s_q.mode == PMCP_RUN)
    else $error("watchdog reset missing");
  slow_div_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R3]
    (s_q.mode == PMCP_RUN && s_q.slow_state_enable && s_q.slow_divider_select == 2'h0
     && s_q.cpu_en && $stable(s_q.slow_state_enable)) |=> !s_q.cpu_en)
    else $error("slow divide wrong");
  periph_halt_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
    s_q.mode == PMCP_HALT |-> !s_q.per_en)
    else $error("peripheral clock running in halt");
  wait_entry_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R5]
    (s_q.mode == PMCP_RUN && i_wait_req && !i_halt_req) |=> s_q.mode == PMCP_WAIT)
    else $error("wait not entered");
  sequence halt_idle_s;
    s_q.mode == PMCP_HALT && !xrst_q && !halt_wake;
  endsequence
  halt_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R8]
    halt_idle_s |=> s_q.mode == PMCP_HALT)
    else $error("halt left without wake source");
endmodule : pmcp_ctrl

/* File: sim/pmcp_cpu_model.sv */
// Behavioural model of the CPU core that issues wait and halt instructions.
module pmcp_cpu_model
  import pmcp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_force_imask,
  input  wire logic [1:0] i_imask_value,
  input  wire logic       i_resume_irq,
  output logic            o_wait_req,
  output logic            o_halt_req,
  output logic [1:0]      o_cc_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] saved_q;
  initial begin
    o_wait_req = 1'b0;
    o_halt_req = 1'b0;
    o_cc_mask  = 2'h3;
    saved_q    = 2'h3;
  end
  // Each instruction is a one-cycle pulse; call it just after a rising edge.
  task exec(input logic halt);
    o_wait_req <= !halt;
    o_halt_req <= halt;
    @(posedge i_clk);
    o_wait_req <= 1'b0;
    o_halt_req <= 1'b0;
  endtask : exec
  always @(posedge i_clk) begin
    if (i_force_imask) begin
      o_cc_mask <= i_imask_value;
    end else if (i_resume_irq) begin
      saved_q   <= o_cc_mask;
      o_cc_mask <= 2'h3;
    end
  end
endmodule : pmcp_cpu_model

/* File: sim/tb_top.sv */
// Self-checking testbench of the power mode controller and prescaler.
`include "pmcp_map.svh"
module tb_top;
  import pmcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, awv, wv, bry, arv, rry, wreq, hreq, wake, awk, xrst, wde, wdc, anyi;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdo, d;
  logic [3:0]  ws;
  logic [1:0]  br, rr, imv, ccm, r;
  logic        awr, wr, bv, arr, rv, cpe, pce, osc, fim, rsi, rsr, wdr, ahl;
  logic [2:0]  md;
  int          error_cnt, checks, n_ri, n_rr, n_wd, c, p;

  pmcp_ctrl DUT (.i_clk(clk), .i_sys_rst(rst), .i_awvalid(awv), .o_awready(awr),
    .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd), .i_wstrb(ws),
    .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rry), .o_rdata(rdo), .o_rresp(rr),
    .i_wait_req(wreq), .i_halt_req(hreq), .i_wake_irq(wake), .i_auto_wake_irq(awk),
    .i_ext_reset(xrst), .i_watchdog_en(wde), .i_watchdog_stop_compat_option(wdc),
    .i_any_irq(anyi), .o_cpu_clock_en(cpe), .o_periph_clock_en(pce), .o_osc_on(osc),
    .o_force_imask(fim), .o_imask_value(imv), .o_resume_irq(rsi), .o_resume_reset(rsr),
    .o_watchdog_reset(wdr), .o_active_halt(ahl), .o_mode(md));
  pmcp_cpu_model cpu (.i_clk(clk), .i_force_imask(fim), .i_imask_value(imv),
    .i_resume_irq(rsi), .o_wait_req(wreq), .o_halt_req(hreq), .o_cc_mask(ccm));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rsi) n_ri++;
    if (rsr) n_rr++;
    if (wdr) n_wd++;
  end

  task stop_test;
    $display("Comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task tmo(input string nm);
    error_cnt++;
    $display("Error %s expected answer seen timeout", nm);
    stop_test;
  endtask : tmo
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ad, dd;
    ad = 0;
    dd = 0;
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    for (n = 0; n < 50 && !(ad && dd); n++) begin
      @(posedge clk);
      if (awr && !ad) begin ad = 1; awv <= 1'b0; end
      if (wr && !dd) begin dd = 1; wv <= 1'b0; end
    end
    if (!(ad && dd)) tmo("write address or data");
    for (n = 0; n < 50 && !bv; n++) @(posedge clk);
    if (!bv) tmo("write response");
    r = br;
    bry <= 1'b0;
    @(posedge clk);
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    int n;
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) break;
    end
    if (n == 50) tmo("read address");
    arv <= 1'b0;
    for (n = 0; n < 50 && !rv; n++) @(posedge clk);
    if (!rv) tmo("read response");
    d = rdo;
    r = rr;
    rry <= 1'b0;
    @(posedge clk);
  endtask : axi_rd
  task count_en(input int cyc);
    c = 0;
    p = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (cpe) c++;
      if (pce) p++;
    end
  endtask : count_en
  task wait_mode(input logic [2:0] m);
    int n;
    for (n = 0; n < 5000 && md !== m; n++) @(posedge clk);
    if (md !== m) tmo("mode");
  endtask : wait_mode
  task pulse_irq;
    anyi <= 1'b1;
    @(posedge clk);
    anyi <= 1'b0;
  endtask : pulse_irq

  task t_reset;
    chk("mode", PMCP_RUN, md);
    chk("osc on", 1, osc);
    axi_rd(`PMCP_OFF_CLK_CTRL);
    chk("ctrl reg", 0, d);
    chk("ctrl rresp", `PMCP_RESP_OKAY, r);
    count_en(16);
    chk("cpu enables", 16, c);
    $display("reset test done");
  endtask : t_reset
  task t_slow;
    for (int s = 0; s < 4; s++) begin
      axi_wr(`PMCP_OFF_CLK_CTRL, 32'h4 | s);
      chk("slow bresp", `PMCP_RESP_OKAY, r);
      repeat (4) @(posedge clk);
      count_en(64);
      chk("slow cpu enables", 64 >> (s + 1), c);
      chk("slow periph enables", 64 >> (s + 1), p);
    end
    axi_wr(`PMCP_OFF_CLK_CTRL, 32'h5);
    cpu.exec(1'b0);
    wait_mode(PMCP_WAIT);
    count_en(64);
    chk("slow wait cpu", 0, c);
    chk("slow wait periph", 16, p);
    pulse_irq;
    wait_mode(PMCP_RUN);
    axi_wr(`PMCP_OFF_CLK_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    count_en(64);
    chk("slow off enables", 64, c);
    $display("slow test done");
  endtask : t_slow
  task t_act_halt;
    axi_wr(`PMCP_OFF_CLK_CTRL, 32'h8);
    cpu.exec(1'b1);
    repeat (3) @(posedge clk);
    chk("active halt mode", PMCP_ACT_HALT, md);
    chk("active halt flag", 1, ahl);
    chk("active halt osc", 1, osc);
    pulse_irq;
    wait_mode(PMCP_RUN);
    axi_wr(`PMCP_OFF_CLK_CTRL, 32'h0);
    $display("active halt test done");
  endtask : t_act_halt
  task t_halt(input int src, input int stab);
    int n, ri, rr0;
    ri = n_ri;
    rr0 = n_rr;
    cpu.exec(1'b1);
    repeat (3) @(posedge clk);
    chk("halt mode", PMCP_HALT, md);
    chk("cc mask", 2'h2, ccm);
    chk("halt osc", 0, osc);
    count_en(16);
    chk("halt cpu", 0, c);
    chk("halt periph", 0, p);
    axi_rd(`PMCP_OFF_STATUS);
    chk("status in halt", 32'h2, d & 32'h17);
    pulse_irq;
    repeat (8) @(posedge clk);
    chk("plain irq ignored", PMCP_HALT, md);
    if (src == 0) wake <= 1'b1;
    else if (src == 1) xrst <= 1'b1;
    else awk <= 1'b1;
    wait_mode(PMCP_STAB);
    wake <= 1'b0; xrst <= 1'b0; awk <= 1'b0;
    chk("stab osc", 1, osc);
    for (n = 1; n < 5000 && md === PMCP_STAB; n++) @(posedge clk);
    chk("stab cycles", stab, n - 1);
    repeat (3) @(posedge clk);
    chk("resumed", PMCP_RUN, md);
    axi_rd(`PMCP_OFF_STATUS);
    chk("woke by reset", src == 1, d[3]);
    chk("irq resumes", ri + (src != 1), n_ri);
    chk("reset resumes", rr0 + (src == 1), n_rr);
    $display("halt test %0d done", src);
  endtask : t_halt
  task t_wdg;
    wde <= 1'b1;
    wdc <= 1'b0;
    @(posedge clk);
    cpu.exec(1'b1);
    repeat (3) @(posedge clk);
    chk("watchdog resets", 1, n_wd);
    chk("watchdog mode", PMCP_RUN, md);
    wdc <= 1'b1;
    @(posedge clk);
    t_halt(0, `PMCP_STAB_SHORT);
    wde <= 1'b0;
    $display("watchdog test done");
  endtask : t_wdg
  task t_unmapped;
    axi_rd(8'h10);
    chk("unmapped rresp", `PMCP_RESP_SLVERR, r);
    chk("unmapped rdata", 0, d);
    axi_wr(8'h10, 32'hFFFFFFFF);
    chk("unmapped bresp", `PMCP_RESP_SLVERR, r);
    $display("unmapped test done");
  endtask : t_unmapped

  initial begin
    rst = 1'b1; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; wake = 0; awk = 0;
    xrst = 0; wde = 0; wdc = 0; anyi = 0; awa = 0; ara = 0; wd = 0; ws = 4'hF;
    error_cnt = 0; checks = 0; n_ri = 0; n_rr = 0; n_wd = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_slow;
    t_act_halt;
    t_halt(0, `PMCP_STAB_SHORT);
    t_halt(1, `PMCP_STAB_SHORT);
    axi_wr(`PMCP_OFF_AWAKE_CTRL, 32'h3);
    t_halt(2, `PMCP_STAB_LONG);
    axi_wr(`PMCP_OFF_AWAKE_CTRL, 32'h0);
    t_wdg;
    t_unmapped;
    stop_test;
  end
endmodule : tb_top
